/* File: ecl_host.sv */
/*
  Video-controller side of the engine command/status link: sends command frames,
  receives status frames, drives print request and watches the engine's sync and status lines.
  Assumes the engine answers each command with one status frame; pins arrive asynchronously.
*/
`timescale 1ns/1ps
`include "ecl_defines.svh"
module ecl_host
#(
  parameter int BIT_CYC = `ECL_BIT_CYC,
  parameter int HALF_BIT_CYC = `ECL_HALF_BIT_CYC,
  parameter int RESP_TIMEOUT_CYC = `ECL_RESP_TIMEOUT_CYC
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_data_in,
  output logic cmd_ready_out,
  output logic stat_valid_out,
  output logic [7:0] stat_data_out,
  output logic stat_parity_err_out,
  output logic stat_frame_err_out,
  output logic resp_timeout_out,
  output logic init_done_out,
  input wire logic print_req_in,
  output logic engine_ready_out,
  output logic key_change_out,
  output logic page_sync_out,
  output logic line_sync_out,
  output logic command_line_out,
  input wire logic status_line_in,
  input wire logic engine_ready_line_n_in,
  output logic print_request_line_n_out,
  input wire logic panel_key_change_line_n_in,
  input wire logic vsync_n_in,
  input wire logic hsync_n_in
);
  localparam logic [13:0] BIT_L = 14'(BIT_CYC - 1);
  localparam logic [13:0] HALF_L = 14'(HALF_BIT_CYC - 1);
  localparam logic [23:0] TMO_L = 24'(RESP_TIMEOUT_CYC - 1);

  ecl_stream_if fill_if ();
  ecl_stream_if drain_if ();

  // Pin synchronisers and edge detection
  logic [`ECL_PIN_COUNT-1:0] pins_raw;
  logic [`ECL_PIN_COUNT-1:0] meta_r;
  logic [`ECL_PIN_COUNT-1:0] sync_r;
  logic [`ECL_PIN_COUNT-1:0] sync_nxt;
  logic [`ECL_PIN_COUNT-1:0] old_r;
  logic engine_ready_r;
  logic engine_ready_nxt;
  logic key_change_r;
  logic key_change_nxt;
  logic page_sync_r;
  logic page_sync_nxt;
  logic line_sync_r;
  logic line_sync_nxt;

  assign pins_raw = {hsync_n_in, vsync_n_in, panel_key_change_line_n_in, engine_ready_line_n_in, status_line_in};

  always_comb
  begin
    sync_nxt = meta_r;
    engine_ready_nxt = ~sync_r[`ECL_PIN_READY_N];
    key_change_nxt = ~sync_r[`ECL_PIN_KEY_N];
    page_sync_nxt = old_r[`ECL_PIN_VSYNC_N] & ~sync_r[`ECL_PIN_VSYNC_N];
    line_sync_nxt = old_r[`ECL_PIN_HSYNC_N] & ~sync_r[`ECL_PIN_HSYNC_N];
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      // Idle-high reset avoids a false start edge or sync pulse at release
      meta_r <= 5'h1f;
      sync_r <= 5'h1f;
      old_r <= 5'h1f;
      engine_ready_r <= 1'b0;
      key_change_r <= 1'b0;
      page_sync_r <= 1'b0;
      line_sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= pins_raw;
      sync_r <= sync_nxt;
      old_r <= sync_r;
      engine_ready_r <= engine_ready_nxt;
      key_change_r <= key_change_nxt;
      page_sync_r <= page_sync_nxt;
      line_sync_r <= line_sync_nxt;
    end
  end

  // Status receiver
  ecl_pkg::ecl_rx_type rx_st_r;
  ecl_pkg::ecl_rx_type rx_st_nxt;
  logic [13:0] rx_tick_r;
  logic [13:0] rx_tick_nxt;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_cnt_nxt;
  logic [9:0] rx_sh_r;
  logic [9:0] rx_sh_nxt;
  logic stat_valid_r;
  logic stat_valid_nxt;
  logic [7:0] stat_data_r;
  logic [7:0] stat_data_nxt;
  logic perr_r;
  logic perr_nxt;
  logic ferr_r;
  logic ferr_nxt;
  logic rx_line;

  assign rx_line = sync_r[`ECL_PIN_STATUS];

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    rx_tick_nxt = rx_tick_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_sh_nxt = rx_sh_r;
    stat_valid_nxt = 1'b0;
    stat_data_nxt = stat_data_r;
    perr_nxt = perr_r;
    ferr_nxt = ferr_r;
    unique case (rx_st_r)
      ecl_pkg::ecl_rx_idle:
      begin
        if (old_r[`ECL_PIN_STATUS] & ~rx_line)
        begin
          rx_st_nxt = ecl_pkg::ecl_rx_start;
          rx_tick_nxt = HALF_L;
        end
      end
      ecl_pkg::ecl_rx_start:
      begin
        if (rx_tick_r != 14'h0000)
        begin
          rx_tick_nxt = rx_tick_r - 14'h0001;
        end
        else if (rx_line == `ECL_START_BIT)
        begin
          rx_st_nxt = ecl_pkg::ecl_rx_data;
          rx_tick_nxt = BIT_L;
          rx_cnt_nxt = `ECL_RX_TAIL_BITS;
        end
        else
        begin
          rx_st_nxt = ecl_pkg::ecl_rx_idle;
        end
      end
      ecl_pkg::ecl_rx_data:
      begin
        if (rx_tick_r != 14'h0000)
        begin
          rx_tick_nxt = rx_tick_r - 14'h0001;
        end
        else
        begin
          rx_tick_nxt = BIT_L;
          rx_sh_nxt = {rx_line, rx_sh_r[9:1]};
          rx_cnt_nxt = rx_cnt_r - 4'h1;
          if (rx_cnt_r == 4'h1)
          begin
            rx_st_nxt = ecl_pkg::ecl_rx_idle;
            stat_valid_nxt = 1'b1;
            stat_data_nxt = rx_sh_nxt[7:0];
            perr_nxt = ~(^rx_sh_nxt[8:0]);
            ferr_nxt = (rx_sh_nxt[9] != `ECL_STOP_BIT);
          end
        end
      end
      default:
      begin
        rx_st_nxt = ecl_pkg::ecl_rx_idle;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_st_r <= ecl_pkg::ecl_rx_idle;
      rx_tick_r <= 14'h0000;
      rx_cnt_r <= 4'h0;
      rx_sh_r <= 10'h000;
      stat_valid_r <= 1'b0;
      stat_data_r <= 8'h00;
      perr_r <= 1'b0;
      ferr_r <= 1'b0;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      rx_tick_r <= rx_tick_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      stat_valid_r <= stat_valid_nxt;
      stat_data_r <= stat_data_nxt;
      perr_r <= perr_nxt;
      ferr_r <= ferr_nxt;
    end
  end

  // Command transmitter and handshake sequencer
  ecl_pkg::ecl_state_type st_r;
  ecl_pkg::ecl_state_type st_nxt;
  logic [10:0] tx_sh_r;
  logic [10:0] tx_sh_nxt;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_cnt_nxt;
  logic [13:0] tx_tick_r;
  logic [13:0] tx_tick_nxt;
  logic [23:0] tmo_r;
  logic [23:0] tmo_nxt;
  logic tmo_pulse_r;
  logic tmo_pulse_nxt;
  logic init_done_r;
  logic init_done_nxt;
  logic cmd_line_r;
  logic cmd_line_nxt;
  logic pr_line_n_r;
  logic pr_line_n_nxt;
  logic line_free;
  ecl_pkg::ecl_byte_type tx_byte;

  ecl_buf2 u_buf
  (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .fill_s(fill_if),
    .drain_s(drain_if)
  );

  assign fill_if.valid = cmd_valid_in;
  assign fill_if.data = cmd_data_in;

  always_comb
  begin
    // A status frame in progress blocks any new command
    line_free = (st_r == ecl_pkg::ecl_st_idle) && (rx_st_r == ecl_pkg::ecl_rx_idle);
    drain_if.ready = line_free & init_done_r;
    tx_byte = init_done_r ? drain_if.data : `ECL_INIT_CMD;
    st_nxt = st_r;
    tx_sh_nxt = tx_sh_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_tick_nxt = tx_tick_r;
    tmo_nxt = tmo_r;
    tmo_pulse_nxt = 1'b0;
    init_done_nxt = init_done_r;
    unique case (st_r)
      ecl_pkg::ecl_st_idle:
      begin
        if (line_free && (~init_done_r || drain_if.valid))
        begin
          st_nxt = ecl_pkg::ecl_st_send;
          tx_sh_nxt = {`ECL_STOP_BIT, ~(^tx_byte), tx_byte, `ECL_START_BIT};
          tx_cnt_nxt = `ECL_TX_FRAME_BITS;
          tx_tick_nxt = BIT_L;
        end
      end
      ecl_pkg::ecl_st_send:
      begin
        if (tx_tick_r != 14'h0000)
        begin
          tx_tick_nxt = tx_tick_r - 14'h0001;
        end
        else
        begin
          tx_tick_nxt = BIT_L;
          tx_sh_nxt = {`ECL_LINE_IDLE, tx_sh_r[10:1]};
          tx_cnt_nxt = tx_cnt_r - 4'h1;
          if (tx_cnt_r == 4'h1)
          begin
            st_nxt = ecl_pkg::ecl_st_wait;
            tmo_nxt = TMO_L;
          end
        end
      end
      ecl_pkg::ecl_st_wait:
      begin
        if (stat_valid_r)
        begin
          st_nxt = ecl_pkg::ecl_st_idle;
          init_done_nxt = 1'b1;
        end
        else if (tmo_r == 24'h000000)
        begin
          // No answer: the link is not trusted, so init is retried before user commands
          st_nxt = ecl_pkg::ecl_st_idle;
          tmo_pulse_nxt = 1'b1;
          init_done_nxt = 1'b0;
        end
        else
        begin
          tmo_nxt = tmo_r - 24'h000001;
        end
      end
      default:
      begin
        st_nxt = ecl_pkg::ecl_st_idle;
      end
    endcase
    cmd_line_nxt = (st_nxt == ecl_pkg::ecl_st_send) ? tx_sh_nxt[0] : `ECL_LINE_IDLE;
    pr_line_n_nxt = ~(print_req_in & init_done_r);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r <= ecl_pkg::ecl_st_idle;
      tx_sh_r <= 11'h7ff;
      tx_cnt_r <= 4'h0;
      tx_tick_r <= 14'h0000;
      tmo_r <= 24'h000000;
      tmo_pulse_r <= 1'b0;
      init_done_r <= 1'b0;
      cmd_line_r <= 1'b1;
      pr_line_n_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_tick_r <= tx_tick_nxt;
      tmo_r <= tmo_nxt;
      tmo_pulse_r <= tmo_pulse_nxt;
      init_done_r <= init_done_nxt;
      cmd_line_r <= cmd_line_nxt;
      pr_line_n_r <= pr_line_n_nxt;
    end
  end

  assign cmd_ready_out = fill_if.ready;
  assign stat_valid_out = stat_valid_r;
  assign stat_data_out = stat_data_r;
  assign stat_parity_err_out = perr_r;
  assign stat_frame_err_out = ferr_r;
  assign resp_timeout_out = tmo_pulse_r;
  assign init_done_out = init_done_r;
  assign engine_ready_out = engine_ready_r;
  assign key_change_out = key_change_r;
  assign page_sync_out = page_sync_r;
  assign line_sync_out = line_sync_r;
  assign command_line_out = cmd_line_r;
  assign print_request_line_n_out = pr_line_n_r;
endmodule : ecl_host

/* File: ecl_defines.svh */
/*
  Constants of the engine command/status link controller: serial timing, frame layout,
  handshake timeout and line levels.
  Assumes a 100 MHz system clock and an engine on the far side that answers every command.
*/
`ifndef ECL_DEFINES_SVH
`define ECL_DEFINES_SVH

`define ECL_CLK_HZ 100000000
`define ECL_BAUD 9600
`define ECL_BIT_CYC ((`ECL_CLK_HZ + (`ECL_BAUD / 2)) / `ECL_BAUD)
`define ECL_HALF_BIT_CYC (`ECL_BIT_CYC / 2)
`define ECL_RESP_TIMEOUT_MS 100
`define ECL_RESP_TIMEOUT_CYC (`ECL_RESP_TIMEOUT_MS * (`ECL_CLK_HZ / 1000))
`define ECL_INIT_CMD 8'h00
`define ECL_DATA_BITS 8
`define ECL_TX_FRAME_BITS 4'hb
`define ECL_RX_TAIL_BITS 4'ha
`define ECL_LINE_IDLE 1'b1
`define ECL_START_BIT 1'b0
`define ECL_STOP_BIT 1'b1
`define ECL_BUF_DEPTH 2
`define ECL_PIN_STATUS 0
`define ECL_PIN_READY_N 1
`define ECL_PIN_KEY_N 2
`define ECL_PIN_VSYNC_N 3
`define ECL_PIN_HSYNC_N 4
`define ECL_PIN_COUNT 5

`endif

/* File: ecl_pkg.sv */
/*
  Types of the engine command/status link controller.
  Assumes nothing beyond the constants header.
*/
package ecl_pkg;

  typedef enum logic [2:0]
  {
    ecl_st_idle = 3'b001,
    ecl_st_send = 3'b010,
    ecl_st_wait = 3'b100
  } ecl_state_type;

  typedef enum logic [2:0]
  {
    ecl_rx_idle = 3'b001,
    ecl_rx_start = 3'b010,
    ecl_rx_data = 3'b100
  } ecl_rx_type;

  typedef logic [7:0] ecl_byte_type;

endpackage : ecl_pkg

/* File: ecl_stream_if.sv */
/*
  Byte stream with valid and ready between the controller's own modules.
  Assumes one clock domain; a word moves when valid and ready are both high at a clock edge.
*/
`timescale 1ns/1ps
interface ecl_stream_if;
  logic valid;
  logic ready;
  ecl_pkg::ecl_byte_type data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ecl_stream_if

/* File: ecl_buf2.sv */
/*
  Two-entry command buffer with valid and ready on both sides.
  Assumes the filling side honours ready and the draining side may stall at any time.
*/
`timescale 1ns/1ps
`include "ecl_defines.svh"
module ecl_buf2
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  ecl_stream_if.snk fill_s,
  ecl_stream_if.src drain_s
);
  ecl_pkg::ecl_byte_type mem_r [`ECL_BUF_DEPTH];
  ecl_pkg::ecl_byte_type mem_nxt [`ECL_BUF_DEPTH];
  logic wr_ptr_r;
  logic wr_ptr_nxt;
  logic rd_ptr_r;
  logic rd_ptr_nxt;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic ready_r;
  logic ready_nxt;
  logic push;
  logic pop;

  assign fill_s.ready = ready_r;
  assign drain_s.valid = (count_r != 2'h0);
  assign drain_s.data = mem_r[rd_ptr_r];

  always_comb
  begin
    push = fill_s.valid & ready_r;
    pop = drain_s.valid & drain_s.ready;
    mem_nxt = mem_r;
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push)
    begin
      mem_nxt[wr_ptr_r] = fill_s.data;
      wr_ptr_nxt = ~wr_ptr_r;
    end
    if (pop)
    begin
      rd_ptr_nxt = ~rd_ptr_r;
    end
    if (push & ~pop)
    begin
      count_nxt = count_r + 2'h1;
    end
    else if (pop & ~push)
    begin
      count_nxt = count_r - 2'h1;
    end
    // Registered ready keeps the user-facing port glitch free
    ready_nxt = (count_nxt != 2'h2);
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'h0;
      ready_r <= 1'b0;
    end
    else
    begin
      mem_r <= mem_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
      ready_r <= ready_nxt;
    end
  end
endmodule : ecl_buf2

/* File: ecl_host_properties.sv */
/*
  Checker on the top ports of the link controller.
  Assumes it is bound onto ecl_host and shares its bit counts.
*/
`timescale 1ns/1ps
module ecl_host_properties
#(
  parameter int BIT_CYC = 16,
  parameter int HALF_BIT_CYC = 8,
  parameter int RESP_TIMEOUT_CYC = 2000
)
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic stat_valid_out,
  input wire logic stat_parity_err_out,
  input wire logic stat_frame_err_out,
  input wire logic resp_timeout_out,
  input wire logic init_done_out,
  input wire logic print_req_in,
  input wire logic engine_ready_out,
  input wire logic page_sync_out,
  input wire logic command_line_out,
  input wire logic status_line_in,
  input wire logic engine_ready_line_n_in,
  input wire logic print_request_line_n_out,
  input wire logic vsync_n_in
);
  int low_r, low_nxt, tx_r, tx_nxt, rx_r, rx_nxt, age_r, age_nxt;
  logic cl_r, cl_nxt, sl_r, sl_nxt, wait_r, wait_nxt;

  always_comb
  begin
    low_nxt = command_line_out ? 0 : low_r + 1;
    tx_nxt = tx_r > 0 ? tx_r - 1 : 0;
    if (tx_r == 0 && cl_r && !command_line_out)
      tx_nxt = 11 * BIT_CYC - 1;
    rx_nxt = rx_r > 0 ? rx_r - 1 : 0;
    // Window closes at the stop sample, so a prompt next command is legal
    if (rx_r == 0 && sl_r && !status_line_in)
      rx_nxt = 10 * BIT_CYC + HALF_BIT_CYC;
    wait_nxt = tx_r == 1 ? 1'b1 : wait_r;
    if (stat_valid_out || resp_timeout_out)
      wait_nxt = 1'b0;
    age_nxt = age_r < 8 ? age_r + 1 : 8;
    cl_nxt = command_line_out;
    sl_nxt = status_line_in;
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      low_r <= 0;
      tx_r <= 0;
      rx_r <= 0;
      age_r <= 0;
      wait_r <= 1'b0;
      cl_r <= 1'b1;
      sl_r <= 1'b1;
    end
    else
    begin
      low_r <= low_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      age_r <= age_nxt;
      wait_r <= wait_nxt;
      cl_r <= cl_nxt;
      sl_r <= sl_nxt;
    end
  end

  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  sequence tx_start_s;
    $fell(command_line_out) && tx_r == 0;
  endsequence

  bit_time_a: assert property ($rose(command_line_out) |-> low_r % BIT_CYC == 0)
    else $error("command low run not whole bits");
  half_duplex_a: assert property (tx_start_s |-> rx_r == 0)
    else $error("command started during status frame");
  wait_turn_a: assert property (tx_start_s |-> !wait_r || stat_valid_out || resp_timeout_out)
    else $error("command sent out of turn");
  frame_done_a: assert property (stat_valid_out |-> rx_r == 0 && $past(rx_r, 8) != 0)
    else $error("status reported off frame timing");
  err_hold_a: assert property (!stat_valid_out |-> $stable(stat_parity_err_out) && $stable(stat_frame_err_out))
    else $error("error flags moved without status");
  req_gate_a: assert property (print_request_line_n_out == !($past(print_req_in) && $past(init_done_out)))
    else $error("print request line wrong");
  ready_lat_a: assert property (age_r == 8 |-> engine_ready_out == !$past(engine_ready_line_n_in, 3))
    else $error("engine ready not followed");
  page_edge_a: assert property (age_r == 8 |-> page_sync_out == ($past(vsync_n_in, 4) && !$past(vsync_n_in, 3)))
    else $error("page sync pulse wrong");
  init_retry_a: assert property (resp_timeout_out |=> !init_done_out ##[0:4] tx_start_s)
    else $error("no init resend after timeout");
endmodule : ecl_host_properties

bind ecl_host ecl_host_properties #(.BIT_CYC(BIT_CYC), .HALF_BIT_CYC(HALF_BIT_CYC),
  .RESP_TIMEOUT_CYC(RESP_TIMEOUT_CYC)) chk (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
  .stat_valid_out(stat_valid_out), .stat_parity_err_out(stat_parity_err_out),
  .stat_frame_err_out(stat_frame_err_out), .resp_timeout_out(resp_timeout_out),
  .init_done_out(init_done_out), .print_req_in(print_req_in), .engine_ready_out(engine_ready_out),
  .page_sync_out(page_sync_out), .command_line_out(command_line_out), .status_line_in(status_line_in),
  .engine_ready_line_n_in(engine_ready_line_n_in), .print_request_line_n_out(print_request_line_n_out),
  .vsync_n_in(vsync_n_in));

/* File: ecl_engine_model.sv */
/*
  Behavioural engine: takes command frames, answers each with one status frame unless mute_in is high.
  Assumes the bench sets the answer and fault controls before a command ends.
*/
`timescale 1ns/1ps
module ecl_engine_model
#(
  parameter int BIT_CYC = 16,
  parameter int HALF_BIT_CYC = 8
)
(
  input wire logic clk_sys_in,
  input wire logic command_line_in,
  input wire logic [7:0] answer_in,
  input wire logic mute_in,
  input wire logic slow_in,
  input wire logic bad_parity_in,
  input wire logic bad_stop_in,
  output logic status_line_out,
  output logic [7:0] cmd_byte_out,
  output logic cmd_ok_out,
  output int cmd_count_out
);
  logic [10:0] rx;
  logic [10:0] tx;
  event got;

  // Receiver runs apart from the sender so a prompt command is never missed
  initial
  begin
    cmd_count_out = 0;
    cmd_ok_out = 1'b0;
    cmd_byte_out = 8'h00;
    forever
    begin
      @(negedge command_line_in);
      repeat (HALF_BIT_CYC) @(posedge clk_sys_in);
      rx[0] = command_line_in;
      for (int i = 1; i < 11; i++)
      begin
        repeat (BIT_CYC) @(posedge clk_sys_in);
        rx[i] = command_line_in;
      end
      cmd_byte_out = rx[8:1];
      cmd_ok_out = !rx[0] && (^rx[9:1]) && rx[10];
      cmd_count_out++;
      ->got;
    end
  end

  initial
  begin
    status_line_out = 1'b1;
    forever
    begin
      @(got);
      if (!mute_in)
      begin
        tx = {!bad_stop_in, (~^answer_in) ^ bad_parity_in, answer_in, 1'b0};
        repeat ((slow_in ? 40 : 3) * BIT_CYC) @(posedge clk_sys_in);
        for (int i = 0; i < 11; i++)
        begin
          #1 status_line_out = tx[i];
          repeat (BIT_CYC) @(posedge clk_sys_in);
        end
        #1 status_line_out = 1'b1;
      end
    end
  end
endmodule : ecl_engine_model

/* File: ecl_host_tb_top.sv */
/*
  Self-checking bench of the link controller against the engine model.
  Assumes short bit and timeout counts; inputs move 1 ns after the clock edge.
*/
`timescale 1ns/1ps
`include "ecl_defines.svh"
module ecl_host_tb_top;
  localparam int BIT_CYC = 16;
  localparam int TO_CYC = 2000;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic print_req = 1'b0;
  logic ready_n = 1'b1;
  logic key_n = 1'b1;
  logic vsync_n = 1'b1;
  logic hsync_n = 1'b1;
  logic [7:0] answer = 8'h5a;
  logic mute = 1'b0;
  logic bad_par = 1'b0;
  logic bad_stop = 1'b0;
  logic slow = 1'b0;
  logic cmd_ready, stat_valid, par_err, frm_err, tmo, init_done, eng_rdy, key_chg, page_sync, line_sync;
  logic cmd_line, stat_line, prq_n, m_ok;
  logic [7:0] stat_data, m_byte;
  int m_cnt;
  int fails = 0;
  int comparisons = 0;

  always #5 clk_sys_in = ~clk_sys_in;

  ecl_host #(.BIT_CYC(BIT_CYC), .HALF_BIT_CYC(BIT_CYC / 2), .RESP_TIMEOUT_CYC(TO_CYC)) dut
  (
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid), .cmd_data_in(cmd_data),
    .cmd_ready_out(cmd_ready), .stat_valid_out(stat_valid), .stat_data_out(stat_data),
    .stat_parity_err_out(par_err), .stat_frame_err_out(frm_err), .resp_timeout_out(tmo),
    .init_done_out(init_done), .print_req_in(print_req), .engine_ready_out(eng_rdy),
    .key_change_out(key_chg), .page_sync_out(page_sync), .line_sync_out(line_sync),
    .command_line_out(cmd_line), .status_line_in(stat_line), .engine_ready_line_n_in(ready_n),
    .print_request_line_n_out(prq_n), .panel_key_change_line_n_in(key_n), .vsync_n_in(vsync_n),
    .hsync_n_in(hsync_n)
  );

  ecl_engine_model #(.BIT_CYC(BIT_CYC), .HALF_BIT_CYC(BIT_CYC / 2)) engine
  (
    .clk_sys_in(clk_sys_in), .command_line_in(cmd_line), .answer_in(answer), .mute_in(mute),
    .slow_in(slow), .bad_parity_in(bad_par), .bad_stop_in(bad_stop), .status_line_out(stat_line),
    .cmd_byte_out(m_byte), .cmd_ok_out(m_ok), .cmd_count_out(m_cnt)
  );

  task automatic check(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : cyc

  // Leaves valid high so back-to-back bytes never toggle it in one step
  task automatic push(input logic [7:0] d);
    cmd_valid = 1'b1;
    cmd_data = d;
    while (cmd_ready !== 1'b1)
      cyc(1);
    cyc(1);
  endtask : push

  task automatic wait_stat(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && !seen; i++)
    begin
      cyc(1);
      seen = stat_valid;
    end
  endtask : wait_stat

  task automatic t_init;
    logic seen;
    wait_stat(3000, seen);
    check(seen && m_cnt == 1 && m_byte === `ECL_INIT_CMD && m_ok === 1'b1, "init frame");
    check(stat_data === 8'h5a && par_err === 1'b0 && frm_err === 1'b0, "status byte");
    cyc(2);
    check(init_done === 1'b1, "init not done");
    $display("t_init done");
  endtask : t_init

  task automatic t_stream;
    logic [7:0] e [3] = '{8'h01, 8'h80, 8'hff};
    logic seen;
    int n0;
    n0 = m_cnt;
    slow = 1'b1;
    answer = 8'hc3;
    foreach (e[i])
      push(e[i]);
    cmd_valid = 1'b0;
    cyc(2);
    check(cmd_ready === 1'b0, "buffer not full");
    foreach (e[i])
    begin
      wait_stat(3000, seen);
      check(seen && m_byte === e[i] && m_ok === 1'b1 && m_cnt == n0 + i + 1, "command order");
      check(stat_data === 8'hc3, "status data");
    end
    slow = 1'b0;
    $display("t_stream done");
  endtask : t_stream

  task automatic t_errors;
    logic seen;
    for (int k = 0; k < 2; k++)
    begin
      bad_par = k == 0;
      bad_stop = k == 1;
      push(8'h3c);
      cmd_valid = 1'b0;
      wait_stat(3000, seen);
      check(seen && par_err === bad_par && frm_err === bad_stop, "error flags");
    end
    bad_par = 1'b0;
    bad_stop = 1'b0;
    $display("t_errors done");
  endtask : t_errors

  task automatic t_timeout;
    logic seen;
    mute = 1'b1;
    push(8'h77);
    cmd_valid = 1'b0;
    seen = 1'b0;
    for (int i = 0; i < TO_CYC + 400 && !seen; i++)
    begin
      cyc(1);
      seen = tmo;
    end
    mute = 1'b0;
    cyc(2);
    check(seen && init_done === 1'b0, "no timeout");
    wait_stat(3000, seen);
    cyc(2);
    check(seen && m_byte === `ECL_INIT_CMD && init_done === 1'b1, "no init resend");
    $display("t_timeout done");
  endtask : t_timeout

  task automatic t_pins;
    int nv;
    int nh;
    ready_n = 1'b0;
    key_n = 1'b0;
    print_req = 1'b1;
    cyc(4);
    check(eng_rdy === 1'b1 && key_chg === 1'b1 && prq_n === 1'b0, "pins active");
    ready_n = 1'b1;
    key_n = 1'b1;
    print_req = 1'b0;
    cyc(4);
    check(eng_rdy === 1'b0 && key_chg === 1'b0 && prq_n === 1'b1, "pins idle");
    for (int k = 0; k < 2; k++)
    begin
      vsync_n = k == 1;
      hsync_n = k == 1;
      nv = 0;
      nh = 0;
      repeat (8)
      begin
        cyc(1);
        nv += page_sync;
        nh += line_sync;
      end
      check(nv == 1 - k && nh == 1 - k, "sync pulses");
    end
    $display("t_pins done");
  endtask : t_pins

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done

  initial
  begin
    repeat (10) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    t_init();
    t_stream();
    t_errors();
    t_timeout();
    t_pins();
    test_done();
  end

  // Whole run needs about 7000 cycles
  initial
  begin
    repeat (40000) @(posedge clk_sys_in);
    fails++;
    $display("ERROR at %0t: watchdog expired", $time);
    test_done();
  end
endmodule : ecl_host_tb_top
